/* File: verilog/cct_top.sv */
/*
   CRC checker counters, checker control, generator gap setting and the
   mode software reset with system/media selection, behind a plain register port.
   Assumes one 100 MHz clock, synchronous inputs and a master that never
   asserts read and write strobes together.
*/
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
module cct_top
   import cct_pkg::*;
#(
   parameter int SRST_LEN = SRST_CYCLES
)
(
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [2:0] i_mode_pins,
   input wire logic i_count_enable,
   input wire cct_rx_type i_rx_copper,
   input wire cct_rx_type i_rx_sgmii,
   input wire cct_rx_type i_rx_qsgmii,
   output logic [DATA_W-1:0] o_rdata,
   output logic o_irq,
   output logic o_sreset_page6,
   output logic o_sreset_page18,
   output logic [2:0] o_sys_mode,
   output logic o_mode_valid,
   output logic o_media_auto,
   output logic [8:0] o_gap_bytes,
   output logic o_counters_valid
);

   localparam logic [SRST_W-1:0] SRST_LAST = SRST_W'(SRST_LEN - 1);

   cct_state_type st;
   cct_state_type next_st;

   cct_rx_type rx_sel;
   logic chk_active;
   logic cnt_clear;
   logic [1:0] cnt_inc;
   logic [1:0][CNT_W-1:0] cnt_val;
   logic [1:0] cnt_sat_hit;
   logic wr_counters;
   logic wr_chk;
   logic wr_gap;
   logic wr_gen;
   logic wr_status;
   logic wr_mask;
   logic [IRQ_W-1:0] irq_event;

   // Picks the traffic source named by the checker field; other codes give no traffic.
   always_comb begin
      case (st.chk_ctrl[CHK_SRC_LSB +: 3])
         CHK_COPPER: rx_sel = i_rx_copper;
         CHK_SGMII: rx_sel = i_rx_sgmii;
         CHK_QSGMII: rx_sel = i_rx_qsgmii;
         default: rx_sel = '0;
      endcase
   end

   // The checker runs only with a valid mode, enabled counters and no reset in progress.
   assign chk_active = st.mode_valid && i_count_enable && (st.phase == ST_RUN);

   // Source code 000 holds the checker in reset, as does the self-clearing reset bit.
   assign cnt_clear = st.chk_ctrl[CNT_CLR_BIT] || (st.chk_ctrl[CHK_SRC_LSB +: 3] == CHK_OFF);

   // Index 0 counts packets, index 1 counts CRC errors.
   assign cnt_inc[0] = chk_active && rx_sel.pkt_done;
   assign cnt_inc[1] = chk_active && rx_sel.pkt_done && rx_sel.crc_bad;

   // One saturating counter per event kind.
   generate
      for (genvar g = 0; g < 2; g++) begin : g_cnt
         cct_sat_counter u_cnt (
            .i_sys_clk(i_sys_clk),
            .i_nrst(i_nrst),
            .i_clear(cnt_clear),
            .i_inc(cnt_inc[g]),
            .o_count(cnt_val[g])
         );
         assign cnt_sat_hit[g] = cnt_inc[g] && !cnt_clear && (cnt_val[g] == (CNT_MAX - 8'h01));
      end
   endgenerate

   // Write decode; the counter register is read only and ignores writes.
   assign wr_counters = i_wr && (i_addr == ADDR_COUNTERS);
   assign wr_chk = i_wr && (i_addr == ADDR_CHK_CTRL);
   assign wr_gap = i_wr && (i_addr == ADDR_GAP_CTRL);
   assign wr_gen = i_wr && (i_addr == ADDR_GEN_CTRL);
   assign wr_status = i_wr && (i_addr == ADDR_IRQ_STATUS);
   assign wr_mask = i_wr && (i_addr == ADDR_IRQ_MASK);

   // Events that set sticky interrupt status bits.
   always_comb begin
      irq_event = '0;
      irq_event[IRQ_PKT] = cnt_inc[0] && !cnt_clear;
      irq_event[IRQ_CRC] = cnt_inc[1] && !cnt_clear;
      irq_event[IRQ_SAT] = |cnt_sat_hit;
      irq_event[IRQ_SRST] = (st.phase == ST_SRESET) && (st.srst_cnt == '0);
   end

   // Next-state logic for the whole register group.
   always_comb begin
      next_st = st;

      // Counter-reset bit lasts one cycle after being written.
      next_st.chk_ctrl[CNT_CLR_BIT] = 1'b0;
      if (wr_chk) begin
         next_st.chk_ctrl = i_wdata;
      end

      if (wr_gap) begin
         next_st.gap_ctrl = i_wdata;
      end
      next_st.gap_bytes = {1'b0, next_st.gap_ctrl[GAP_LSB +: 8]} + 9'h001;

      if (wr_mask) begin
         next_st.irq_mask = i_wdata[IRQ_W-1:0];
      end

      // Write-one-to-clear, with a new event winning over the clear.
      next_st.irq_status = st.irq_status;
      if (wr_status) begin
         next_st.irq_status = st.irq_status & ~i_wdata[IRQ_W-1:0];
      end
      next_st.irq_status = next_st.irq_status | irq_event;
      next_st.irq = |(next_st.irq_status & next_st.irq_mask);

      // Mode phases: pin capture after hardware reset, normal run, software reset.
      case (st.phase)
         ST_BOOT: begin
            next_st.gen_ctrl[SYS_MODE_LSB +: 3] = i_mode_pins;
            next_st.eff_mode = i_mode_pins;
            next_st.phase = ST_RUN;
         end
         ST_RUN: begin
            if (wr_gen) begin
               next_st.gen_ctrl = i_wdata;
               if (i_wdata[GEN_SRST_BIT]) begin
                  next_st.phase = ST_SRESET;
                  next_st.sreset = 1'b1;
                  next_st.srst_cnt = SRST_LAST;
               end
            end
         end
         ST_SRESET: begin
            // Writes land during the reset but the reset bit stays set until done.
            if (wr_gen) begin
               next_st.gen_ctrl = i_wdata;
            end
            next_st.gen_ctrl[GEN_SRST_BIT] = 1'b1;
            if (st.srst_cnt == '0) begin
               next_st.gen_ctrl[GEN_SRST_BIT] = 1'b0;
               next_st.sreset = 1'b0;
               next_st.eff_mode = next_st.gen_ctrl[SYS_MODE_LSB +: 3];
               next_st.phase = ST_RUN;
            end else begin
               next_st.srst_cnt = st.srst_cnt - SRST_W'(1);
            end
         end
         default: begin
            next_st.phase = ST_BOOT;
         end
      endcase

      // Decode of the selection in force; codes 100 to 111 are reserved.
      next_st.mode_valid = (next_st.eff_mode <= MODE_QS_FX);
      next_st.media_auto = (next_st.eff_mode == MODE_QS_FX) && next_st.gen_ctrl[MEDIA_SEL_BIT];
      next_st.cnt_valid = i_count_enable;

      // Read data stand only in the cycle after the read strobe.
      next_st.rdata = '0;
      if (i_rd) begin
         case (i_addr)
            ADDR_COUNTERS: begin
               next_st.rdata[PKT_CNT_LSB +: CNT_W] = cnt_val[0];
               next_st.rdata[CRC_CNT_LSB +: CNT_W] = cnt_val[1];
            end
            ADDR_CHK_CTRL: next_st.rdata = st.chk_ctrl;
            ADDR_GAP_CTRL: next_st.rdata = st.gap_ctrl;
            ADDR_GEN_CTRL: next_st.rdata = st.gen_ctrl;
            ADDR_IRQ_STATUS: next_st.rdata[IRQ_W-1:0] = st.irq_status;
            ADDR_IRQ_MASK: next_st.rdata[IRQ_W-1:0] = st.irq_mask;
            default: next_st.rdata = '0;
         endcase
      end
   end

   // State register; the pin strap is caught by the boot phase, not by the reset.
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st.phase <= ST_BOOT;
         st.chk_ctrl <= CHK_CTRL_RST;
         st.gap_ctrl <= GAP_CTRL_RST;
         st.gen_ctrl <= GEN_CTRL_RST;
         st.eff_mode <= MODE_QS_COPPER;
         st.srst_cnt <= '0;
         st.sreset <= 1'b0;
         st.irq_status <= '0;
         st.irq_mask <= '0;
         st.irq <= 1'b0;
         st.rdata <= '0;
         st.gap_bytes <= 9'h00c;
         st.media_auto <= 1'b0;
         st.mode_valid <= 1'b0;
         st.cnt_valid <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from the state register.
   assign o_rdata = st.rdata;
   assign o_irq = st.irq;
   assign o_sreset_page6 = st.sreset;
   assign o_sreset_page18 = st.sreset;
   assign o_sys_mode = st.eff_mode;
   assign o_mode_valid = st.mode_valid;
   assign o_media_auto = st.media_auto;
   assign o_gap_bytes = st.gap_bytes;
   assign o_counters_valid = st.cnt_valid;

endmodule // cct_top

/* File: pkg/cct_pkg.sv */
/*
   Shared constants and types for the CRC checker and test control group:
   register indices, field positions, reset values, selection codes and timing.
   Assumes a single 100 MHz clock and a plain register port indexed by word.
*/
package cct_pkg;

   // Register port and counter widths.
   localparam int ADDR_W = 5;
   localparam int DATA_W = 16;
   localparam int CNT_W = 8;

   // Register indices on the plain port.
   localparam logic [ADDR_W-1:0] ADDR_COUNTERS = 5'h11;
   localparam logic [ADDR_W-1:0] ADDR_CHK_CTRL = 5'h12;
   localparam logic [ADDR_W-1:0] ADDR_GAP_CTRL = 5'h13;
   localparam logic [ADDR_W-1:0] ADDR_GEN_CTRL = 5'h14;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 5'h15;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 5'h16;

   // Field positions.
   localparam int PKT_CNT_LSB = 8;
   localparam int CRC_CNT_LSB = 0;
   localparam int CNT_CLR_BIT = 4;
   localparam int CHK_SRC_LSB = 0;
   localparam int GAP_LSB = 0;
   localparam int GEN_SRST_BIT = 15;
   localparam int MEDIA_SEL_BIT = 6;
   localparam int SYS_MODE_LSB = 0;

   // Reset values and the counter saturation value.
   localparam logic [DATA_W-1:0] CHK_CTRL_RST = 16'h0000;
   localparam logic [DATA_W-1:0] GAP_CTRL_RST = 16'h000b;
   localparam logic [DATA_W-1:0] GEN_CTRL_RST = 16'h0200;
   localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
   localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;

   // Checker source codes.
   localparam logic [2:0] CHK_OFF = 3'h0;
   localparam logic [2:0] CHK_COPPER = 3'h2;
   localparam logic [2:0] CHK_SGMII = 3'h4;
   localparam logic [2:0] CHK_QSGMII = 3'h6;

   // System and media selection codes; codes above the last are reserved.
   localparam logic [2:0] MODE_QS_COPPER = 3'h0;
   localparam logic [2:0] MODE_SG_COPPER = 3'h1;
   localparam logic [2:0] MODE_QS_1000X = 3'h2;
   localparam logic [2:0] MODE_QS_FX = 3'h3;

   // Interrupt status bits.
   localparam int IRQ_W = 4;
   localparam int IRQ_PKT = 0;
   localparam int IRQ_CRC = 1;
   localparam int IRQ_SAT = 2;
   localparam int IRQ_SRST = 3;

   // Software reset duration, rounded up to whole clock cycles.
   localparam int CLK_PERIOD_PS = 10000;
   localparam int SRST_TIME_NS = 200;
   localparam int SRST_CYCLES = (SRST_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SRST_W = 8;

   // End-of-packet report from one traffic source.
   typedef struct packed {
      logic pkt_done;
      logic crc_bad;
   } cct_rx_type;

   typedef enum logic [1:0] {
      ST_BOOT,
      ST_RUN,
      ST_SRESET
   } cct_phase_type;

   // Whole state of the top module.
   typedef struct packed {
      cct_phase_type phase;
      logic [DATA_W-1:0] chk_ctrl;
      logic [DATA_W-1:0] gap_ctrl;
      logic [DATA_W-1:0] gen_ctrl;
      logic [2:0] eff_mode;
      logic [SRST_W-1:0] srst_cnt;
      logic sreset;
      logic [IRQ_W-1:0] irq_status;
      logic [IRQ_W-1:0] irq_mask;
      logic irq;
      logic [DATA_W-1:0] rdata;
      logic [8:0] gap_bytes;
      logic media_auto;
      logic mode_valid;
      logic cnt_valid;
   } cct_state_type;

   // Whole state of one saturating counter.
   typedef struct packed {
      logic [CNT_W-1:0] count;
   } cct_cnt_state_type;

endpackage

/* File: verilog/cct_sat_counter.sv */
/*
   Saturating event counter with synchronous clear.
   Assumes increment and clear are single-cycle requests in the system clock domain.
*/
`timescale 1ns/1ps
module cct_sat_counter
   import cct_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   input wire logic i_clear,
   input wire logic i_inc,
   output logic [CNT_W-1:0] o_count
);

   cct_cnt_state_type st;
   cct_cnt_state_type next_st;

   // Clear wins over an increment; the count stops at all ones.
   always_comb begin
      next_st = st;
      if (i_clear) begin
         next_st.count = CNT_RST;
      end else if (i_inc && (st.count != CNT_MAX)) begin
         next_st.count = st.count + 8'h01;
      end
   end

   // State register.
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st <= '{count: CNT_RST};
      end else begin
         st <= next_st;
      end
   end

   assign o_count = st.count;

endmodule // cct_sat_counter

/* File: bench/cct_traffic_model.sv */
/*
   Far-side traffic source: end-of-packet reports on the copper, SGMII and QSGMII paths.
   Assumes the bench raises i_go bits for as many cycles as it wants packets.
*/
`timescale 1ns/1ps
module cct_traffic_model
   import cct_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   input wire logic [2:0] i_go,
   input wire logic i_bad,
   output cct_rx_type o_copper,
   output cct_rx_type o_sgmii,
   output cct_rx_type o_qsgmii
);
   // One packet end per cycle per path; outside a packet end the error line toggles, so it means nothing.
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_copper <= '0;
         o_sgmii <= '0;
         o_qsgmii <= '0;
      end else begin
         o_copper <= '{i_go[0], i_go[0] ? i_bad : ~o_copper.crc_bad};
         o_sgmii <= '{i_go[1], i_go[1] ? i_bad : ~o_sgmii.crc_bad};
         o_qsgmii <= '{i_go[2], i_go[2] ? i_bad : ~o_qsgmii.crc_bad};
      end
   end
endmodule // cct_traffic_model

/* File: bench/cct_top_assertions.sv */
/*
   Port checker for cct_top.
   Assumes it is bound onto cct_top and handed the same SRST_LEN.
*/
`timescale 1ns/1ps
module cct_top_assertions
   import cct_pkg::*;
#(
   parameter int SRST_LEN = SRST_CYCLES
)
(
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_count_enable,
   input wire logic [DATA_W-1:0] o_rdata,
   input wire logic o_sreset_page6,
   input wire logic o_sreset_page18,
   input wire logic [2:0] o_sys_mode,
   input wire logic o_mode_valid,
   input wire logic [8:0] o_gap_bytes,
   input wire logic o_counters_valid
);
   logic [1:0] up;
   logic [7:0] hcnt;
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_nrst);
   // Counts edges since reset release up to three, and the cycles of each software reset.
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         up <= 2'h0;
         hcnt <= 8'h00;
      end else begin
         up <= (up == 2'h3) ? up : up + 2'h1;
         hcnt <= o_sreset_page6 ? hcnt + 8'h01 : 8'h00;
      end
   end
   sequence s_srst_req;
      up == 2'h3 && i_wr && i_addr == ADDR_GEN_CTRL && i_wdata[GEN_SRST_BIT] && !o_sreset_page6;
   endsequence
   a_rdata_idle: assert property (!i_rd |=> o_rdata == 16'h0000)
      else $error("read data not zero outside a read answer");
   a_srst_start: assert property (s_srst_req |=> o_sreset_page6)
      else $error("software reset did not start");
   a_srst_len: assert property ($fell(o_sreset_page6) |-> int'(hcnt) == SRST_LEN)
      else $error("software reset length wrong");
   a_pages_same: assert property (o_sreset_page6 == o_sreset_page18)
      else $error("page resets differ");
   a_gap_plus: assert property (i_wr && i_addr == ADDR_GAP_CTRL |=> o_gap_bytes == {1'b0, $past(i_wdata[7:0])} + 9'h001)
      else $error("gap bytes not field plus one");
   a_cnt_valid: assert property (up != 2'h0 |-> o_counters_valid == $past(i_count_enable))
      else $error("counter valid flag does not follow the enable");
   a_mode_hold: assert property (up == 2'h3 && !$past(o_sreset_page6) |-> $stable(o_sys_mode))
      else $error("mode changed without software reset");
   a_mode_legal: assert property (up == 2'h3 |-> o_mode_valid == (o_sys_mode <= MODE_QS_FX))
      else $error("mode valid flag wrong");
endmodule // cct_top_assertions

bind cct_top cct_top_assertions #(.SRST_LEN(SRST_LEN)) i_chk (.i_sys_clk, .i_nrst, .i_addr, .i_wdata, .i_wr, .i_rd,
   .i_count_enable, .o_rdata, .o_sreset_page6, .o_sreset_page18, .o_sys_mode, .o_mode_valid, .o_gap_bytes,
   .o_counters_valid);

/* File: bench/cct_top_test.sv */
/*
   Self-checking bench for cct_top: register calls and traffic bursts with expected values.
   Assumes a short software reset of two cycles and mode pins strapped to 001, then to 010
   for a second hardware reset near the end of the run.
*/
`timescale 1ns/1ps
module cct_top_test
   import cct_pkg::*;
;
   logic i_sys_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic [ADDR_W-1:0] i_addr = '0;
   logic [DATA_W-1:0] i_wdata = '0;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic i_count_enable = 1'b1;
   logic [2:0] pins = 3'h1;
   logic [2:0] go = 3'h0;
   logic bad = 1'b0;
   cct_rx_type rx_c, rx_s, rx_q;
   logic [DATA_W-1:0] o_rdata;
   logic o_irq, o_sreset_page6, o_sreset_page18, o_mode_valid, o_media_auto, o_counters_valid;
   logic [2:0] o_sys_mode;
   logic [8:0] o_gap_bytes;
   int mismatches = 0;
   int n_checks = 0;
   logic [2:0] src [3] = '{CHK_COPPER, CHK_SGMII, CHK_QSGMII};
   cct_traffic_model i_far (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_go(go), .i_bad(bad), .o_copper(rx_c),
      .o_sgmii(rx_s), .o_qsgmii(rx_q));
   cct_top #(.SRST_LEN(2)) i_dut (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .i_mode_pins(pins), .i_count_enable(i_count_enable), .i_rx_copper(rx_c),
      .i_rx_sgmii(rx_s), .i_rx_qsgmii(rx_q), .o_rdata(o_rdata), .o_irq(o_irq), .o_sreset_page6(o_sreset_page6),
      .o_sreset_page18(o_sreset_page18), .o_sys_mode(o_sys_mode), .o_mode_valid(o_mode_valid),
      .o_media_auto(o_media_auto), .o_gap_bytes(o_gap_bytes), .o_counters_valid(o_counters_valid));
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge i_sys_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_sys_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      @(posedge i_sys_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_sys_clk);
      i_rd <= 1'b0;
      #1;
      chk(o_rdata, exp);
   endtask
   task automatic pkts(input logic [2:0] g, input logic b, input int n);
      @(posedge i_sys_clk);
      go <= g;
      bad <= b;
      repeat (n) @(posedge i_sys_clk);
      go <= 3'h0;
      repeat (3) @(posedge i_sys_clk);
      #1;
   endtask
   task automatic srst(input logic [DATA_W-1:0] d);
      int i;
      wr(ADDR_GEN_CTRL, d);
      #1;
      chk(16'({o_sreset_page6, o_sreset_page18}), 16'h0003);
      for (i = 0; i < 50 && o_sreset_page6 !== 1'b0; i++) begin
         @(posedge i_sys_clk);
         #1;
      end
      if (i == 50) begin
         mismatches++;
         wrap_up();
      end
   endtask
   // Free-running 100 MHz clock.
   initial begin
      forever #5 i_sys_clk = ~i_sys_clk;
   end
   // Cuts a hang short.
   initial begin
      #900000;
      mismatches++;
      wrap_up();
   end
   // Main sequence of register calls and traffic bursts.
   initial begin
      repeat (10) @(posedge i_sys_clk);
      i_nrst <= 1'b1;
      repeat (2) @(posedge i_sys_clk);
      rd(ADDR_COUNTERS, 16'h0000);
      rd(ADDR_CHK_CTRL, 16'h0000);
      rd(ADDR_GAP_CTRL, 16'h000b);
      rd(ADDR_GEN_CTRL, 16'h0201);
      chk({13'h0, o_sys_mode}, 16'h0001);
      chk({7'h0, o_gap_bytes}, 16'h000c);
      rd(5'h00, 16'h0000);
      wr(ADDR_COUNTERS, 16'hffff);
      rd(ADDR_COUNTERS, 16'h0000);
      for (int k = 0; k < 3; k++) begin
         wr(ADDR_CHK_CTRL, {13'h0, src[k]});
         pkts(3'h7 ^ (3'h1 << k), 1'b1, 2);
         pkts(3'h1 << k, 1'b1, 2);
         rd(ADDR_COUNTERS, {2{8'(2 * k + 2)}});
      end
      wr(ADDR_CHK_CTRL, 16'h0003);
      pkts(3'h7, 1'b1, 3);
      rd(ADDR_COUNTERS, 16'h0606);
      wr(ADDR_CHK_CTRL, {13'h0, CHK_COPPER});
      i_count_enable <= 1'b0;
      pkts(3'h1, 1'b0, 2);
      chk(16'(o_counters_valid), 16'h0000);
      rd(ADDR_COUNTERS, 16'h0606);
      @(posedge i_sys_clk);
      i_count_enable <= 1'b1;
      pkts(3'h1, 1'b0, 1);
      rd(ADDR_COUNTERS, 16'h0706);
      wr(ADDR_GEN_CTRL, 16'h0243);
      rd(ADDR_GEN_CTRL, 16'h0243);
      chk({13'h0, o_sys_mode}, 16'h0001);
      srst(16'h8243);
      rd(ADDR_COUNTERS, 16'h0706);
      rd(ADDR_GEN_CTRL, 16'h0243);
      chk({13'h0, o_sys_mode}, 16'h0003);
      chk(16'({o_mode_valid, o_media_auto}), 16'h0003);
      srst(16'h8204);
      pkts(3'h1, 1'b1, 2);
      rd(ADDR_COUNTERS, 16'h0706);
      chk(16'(o_mode_valid), 16'h0000);
      srst(16'h8201);
      pkts(3'h1, 1'b1, 260);
      rd(ADDR_COUNTERS, 16'hffff);
      wr(ADDR_CHK_CTRL, 16'h0012);
      rd(ADDR_CHK_CTRL, 16'h0002);
      rd(ADDR_COUNTERS, 16'h0000);
      wr(ADDR_CHK_CTRL, 16'h0000);
      pkts(3'h7, 1'b1, 2);
      rd(ADDR_COUNTERS, 16'h0000);
      wr(ADDR_GAP_CTRL, 16'h00ff);
      rd(ADDR_GAP_CTRL, 16'h00ff);
      chk({7'h0, o_gap_bytes}, 16'h0100);
      rd(ADDR_IRQ_STATUS, 16'h000f);
      chk(16'(o_irq), 16'h0000);
      wr(ADDR_IRQ_MASK, 16'h0004);
      rd(ADDR_IRQ_MASK, 16'h0004);
      chk(16'(o_irq), 16'h0001);
      wr(ADDR_IRQ_STATUS, 16'h0004);
      rd(ADDR_IRQ_STATUS, 16'h000b);
      chk(16'(o_irq), 16'h0000);
      // Second hardware reset with a new strap; the strap must reach the selection field.
      @(posedge i_sys_clk);
      pins <= 3'h2;
      i_nrst <= 1'b0;
      repeat (2) @(posedge i_sys_clk);
      i_nrst <= 1'b1;
      repeat (2) @(posedge i_sys_clk);
      rd(ADDR_GEN_CTRL, 16'h0202);
      rd(ADDR_COUNTERS, 16'h0000);
      rd(ADDR_GAP_CTRL, 16'h000b);
      chk({13'h0, o_sys_mode}, 16'h0002);
      wrap_up();
   end
endmodule // cct_top_test
